/* File: core/cts_selector.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cts_regs.svh"
// Contract
// - Time-response table x points are elapsed milliseconds; y is the output.
// - Control input is on/off; while on, output follows stored profile.
// - At profile end (last point or ignored) hold final output until off.
// - While control input is off, table output is zero.
// - Each off-to-on edge restarts the profile at point zero, zero output; code starts at point zero's output (point one's if it is a jump).
// - Interval between points may be 1 ms up to one day.
// - A digital x source is seen only as zero or one.
// - Selector picks one of up to three tables and forwards its output.
// - Selector works only when enabled; reset leaves it disabled.
// - Candidates evaluated in ascending order; first chosen wins.
// - Each candidate has three conditions comparing two sourced arguments.
// - Comparison code: 0 eq, 1 ne, 2 gt, 3 ge, 4 lt, 5 le.
// - Comparison defaults to equal; changeable only with both sources valid.
// - Condition result: 0 false, 1 true, 2 error, 3 not applicable.
// - Both arguments reset to unused, so conditions are not applicable.
// - Combination: 0 default, 1 and3, 2 or3, 3 (1&2)|3, 4 (1|2)&3.
// - And3 rejects on false or error; not applicable counts as true.
// - Or3 chooses if any true; error and not applicable are false.
// - Mode three: both first two true, or third true.
// - Mode four: third true together with first or second.
// - Reset modes: candidates one and two and3, third default.
// - Ramp segments interpolate linearly; jump segments give the point's output.
// - An ignored point ends the profile at the previous point's output.
// - Selected table without x source makes the output not available.
module cts_selector (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [8:0][15:0] arg_val,
  input wire logic [8:0] arg_err,
  input wire logic [2:0] ctrl_in,
  input wire logic [2:0][15:0] data_tbl_out,
  output logic [15:0] sel_out,
  output logic sel_na,
  output logic [1:0] sel_idx,
  output logic sel_valid
);
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  logic enable_reg;
  logic [11:0] mode_reg;
  logic [2:0] time_mode_reg;
  logic [2:0] src_ok_reg;
  logic [8:0] a1_used_reg;
  logic [8:0] a2_used_reg;
  logic [8:0][2:0] op_reg;
  // Intervals up to one day need 27 bits
  logic [10:0][26:0] px_reg;
  logic [10:0][15:0] py_reg;
  logic [10:0][1:0] pr_reg;

  function automatic logic in_rng(input logic [7:0] a, input logic [7:0] base, input int n);
    in_rng = (a >= base) && (a < base + 8'(n * 4));
  endfunction

  function automatic logic [3:0] widx(input logic [7:0] a, input logic [7:0] base);
    widx = 4'((a - base) >> 2);
  endfunction

  // Control word: bit0 enable, bits 3:1 time mode, bits 6:4 x source present
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= 1'b0;
      time_mode_reg <= 3'h0;
      src_ok_reg <= 3'h0;
    end else if (wr && addr == `CTS_A_CTRL) begin
      enable_reg <= wdata[0];
      time_mode_reg <= wdata[3:1];
      src_ok_reg <= wdata[6:4];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= `CTS_MODE_RST;
    end else if (wr && addr == `CTS_A_MODE) begin
      mode_reg <= wdata[11:0];
    end
  end

  // Condition word: bit0 arg1 used, bit1 arg2 used, bits 6:4 operator
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a1_used_reg <= 9'h000;
      a2_used_reg <= 9'h000;
      op_reg <= '0;
    end else if (wr && in_rng(addr, `CTS_A_COND, 9)) begin
      a1_used_reg[widx(addr, `CTS_A_COND)] <= wdata[0];
      a2_used_reg[widx(addr, `CTS_A_COND)] <= wdata[1];
      if (wdata[0] && wdata[1] && wdata[6:4] <= 3'h5) begin
        op_reg[widx(addr, `CTS_A_COND)] <= wdata[6:4];
      end else begin
        op_reg[widx(addr, `CTS_A_COND)] <= 3'h0;
      end
    end
  end

  // Profile points, shared by the time-response tables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // A 1 ms reset interval keeps the ramp divisor nonzero
      px_reg <= {`CTS_NPTS{`CTS_PX_MIN}};
      py_reg <= '0;
      pr_reg <= '0;
    end else if (wr && in_rng(addr, `CTS_A_PX, `CTS_NPTS)) begin
      if (wdata > `CTS_DAY_MS) begin
        px_reg[widx(addr, `CTS_A_PX)] <= 27'(`CTS_DAY_MS);
      end else if (wdata == 32'h0) begin
        px_reg[widx(addr, `CTS_A_PX)] <= `CTS_PX_MIN;
      end else begin
        px_reg[widx(addr, `CTS_A_PX)] <= wdata[26:0];
      end
    end else if (wr && in_rng(addr, `CTS_A_PY, `CTS_NPTS)) begin
      py_reg[widx(addr, `CTS_A_PY)] <= wdata[15:0];
    end else if (wr && in_rng(addr, `CTS_A_PR, `CTS_NPTS)) begin
      pr_reg[widx(addr, `CTS_A_PR)] <= wdata[1:0];
    end
  end

  // Free-running tick: the first step after a start may come up to 1 ms early
  logic [17:0] tick_cnt;
  logic ms_tick;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 18'h0;
    end else if (tick_cnt == 18'(`CTS_MS_CYC - 1)) begin
      tick_cnt <= 18'h0;
    end else begin
      tick_cnt <= tick_cnt + 18'h1;
    end
  end
  assign ms_tick = (tick_cnt == 18'(`CTS_MS_CYC - 1));

  logic [2:0] ctrl_d_reg;
  logic [2:0][3:0] pt_reg;
  logic [2:0][26:0] el_reg;
  logic [2:0] done_reg;
  logic [2:0][15:0] prof_out;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_prof
      logic on;
      logic [3:0] nx;
      logic last;
      assign on = ctrl_in[g];
      assign nx = pt_reg[g] + 4'h1;
      assign last = (pt_reg[g] == 4'(`CTS_NPTS - 1)) || (pr_reg[nx] == 2'h2);
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pt_reg[g] <= 4'h0;
          el_reg[g] <= 27'h0;
          done_reg[g] <= 1'b0;
          ctrl_d_reg[g] <= 1'b0;
        end else begin
          ctrl_d_reg[g] <= on;
          if (!on || !ctrl_d_reg[g]) begin
            pt_reg[g] <= 4'h0;
            el_reg[g] <= 27'h0;
            done_reg[g] <= 1'b0;
          end else if (ms_tick && !done_reg[g]) begin
            if (last) begin
              done_reg[g] <= 1'b1;
            end else if (el_reg[g] + 27'h1 >= px_reg[nx]) begin
              pt_reg[g] <= nx;
              el_reg[g] <= 27'h0;
            end else begin
              el_reg[g] <= el_reg[g] + 27'h1;
            end
          end
        end
      end
      logic signed [17:0] dy;
      logic signed [45:0] prod;
      always_comb begin
        dy = 18'(signed'({1'b0, py_reg[nx]})) - 18'(signed'({1'b0, py_reg[pt_reg[g]]}));
        prod = 46'(dy) * 46'(signed'({1'b0, el_reg[g]}));
        if (!on) begin
          prof_out[g] = 16'h0;
        end else if (done_reg[g] || last) begin
          prof_out[g] = py_reg[pt_reg[g]];
        end else if (pr_reg[nx] == 2'h1) begin
          prof_out[g] = py_reg[nx];
        end else begin
          prof_out[g] = 16'(46'(signed'({1'b0, py_reg[pt_reg[g]]})) +
            prod / 46'(signed'({1'b0, px_reg[nx]})));
        end
      end
    end
  endgenerate

  function automatic cts_pkg::cts_res_t eval_cond(input logic u1, input logic u2,
    input logic e1, input logic e2, input logic [2:0] op, input logic [15:0] a,
    input logic [15:0] b);
    logic t;
    t = 1'b0;
    case (op)
      3'h0: t = (a == b);
      3'h1: t = (a != b);
      3'h2: t = (a > b);
      3'h3: t = (a >= b);
      3'h4: t = (a < b);
      3'h5: t = (a <= b);
      default: t = 1'b0;
    endcase
    if (!u1 || !u2) begin
      eval_cond = cts_pkg::CTS_RES_NA;
    end else if (e1 || e2) begin
      eval_cond = cts_pkg::CTS_RES_ERR;
    end else begin
      eval_cond = t ? cts_pkg::CTS_RES_TRUE : cts_pkg::CTS_RES_FALSE;
    end
  endfunction

  cts_pkg::cts_res_t [8:0] res;
  logic [2:0] pick;
  generate
    for (g = 0; g < 9; g++) begin : gen_cond
      // Each argument carries the error flag of its own slot
      assign res[g] = eval_cond(a1_used_reg[g], a2_used_reg[g], arg_err[g], arg_err[(g + 1) % 9],
        op_reg[g], arg_val[g], arg_val[(g + 1) % 9]);
    end
    for (g = 0; g < 3; g++) begin : gen_pick
      logic t1, t2, t3, ok;
      always_comb begin
        t1 = res[3 * g] == cts_pkg::CTS_RES_TRUE;
        t2 = res[3 * g + 1] == cts_pkg::CTS_RES_TRUE;
        t3 = res[3 * g + 2] == cts_pkg::CTS_RES_TRUE;
        case (mode_reg[4 * g +: 3])
          3'h0: ok = 1'b1;
          3'h1: ok = (t1 || res[3 * g] == cts_pkg::CTS_RES_NA) &&
            (t2 || res[3 * g + 1] == cts_pkg::CTS_RES_NA) &&
            (t3 || res[3 * g + 2] == cts_pkg::CTS_RES_NA);
          3'h2: ok = t1 || t2 || t3;
          3'h3: ok = (t1 && t2) || t3;
          3'h4: ok = (t1 || t2) && t3;
          default: ok = 1'b0;
        endcase
      end
      assign pick[g] = ok;
    end
  endgenerate

  logic [1:0] idx;
  logic any;
  always_comb begin
    any = 1'b1;
    if (pick[0]) begin
      idx = 2'h0;
    end else if (pick[1]) begin
      idx = 2'h1;
    end else if (pick[2]) begin
      idx = 2'h2;
    end else begin
      idx = 2'h0;
      any = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_out <= 16'h0;
      sel_na <= 1'b0;
      sel_idx <= 2'h0;
      sel_valid <= 1'b0;
    end else begin
      sel_valid <= enable_reg && any;
      sel_idx <= idx;
      sel_na <= enable_reg && any && !src_ok_reg[idx];
      sel_out <= (enable_reg && any && src_ok_reg[idx]) ?
        (time_mode_reg[idx] ? prof_out[idx] : data_tbl_out[idx]) : 16'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `CTS_NO_READ;
    end else if (rd && in_rng(addr, `CTS_A_COND, 9)) begin
      // Operator reads back as stored, so a refused one shows as equal
      rdata <= {25'h0, op_reg[widx(addr, `CTS_A_COND)], 2'h0,
        a2_used_reg[widx(addr, `CTS_A_COND)], a1_used_reg[widx(addr, `CTS_A_COND)]};
    end else if (rd) begin
      case (addr)
        `CTS_A_CTRL: rdata <= {25'h0, src_ok_reg, time_mode_reg, enable_reg};
        `CTS_A_STAT: rdata <= {23'h0, done_reg, sel_na, sel_valid, sel_idx, 2'h0};
        `CTS_A_OUT: rdata <= {16'h0, sel_out};
        `CTS_A_MODE: rdata <= {20'h0, mode_reg};
        default: rdata <= `CTS_NO_READ;
      endcase
    end
  end

  a_reset_off: assert property (@(posedge clk) disable iff (!rst_n)
    !enable_reg |=> !sel_valid) else $error("output valid while disabled");
  a_off_output: assert property (@(posedge clk) disable iff (!rst_n)
    !enable_reg |=> sel_out == 16'h0) else $error("output while disabled");
  a_off_zero: assert property (@(posedge clk) disable iff (!rst_n)
    !ctrl_in[0] |-> prof_out[0] == 16'h0) else $error("profile not zero when off");
  a_restart_point: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(ctrl_in[0]) |=> pt_reg[0] == 4'h0) else $error("profile not restarted");
  a_first_wins: assert property (@(posedge clk) disable iff (!rst_n)
    enable_reg && pick[0] |=> sel_idx == 2'h0) else $error("priority broken");
  a_second_pick: assert property (@(posedge clk) disable iff (!rst_n)
    enable_reg && !pick[0] && pick[1] |=> sel_idx == 2'h1) else $error("second table missed");
  a_default_mode: assert property (@(posedge clk) disable iff (!rst_n)
    mode_reg[2:0] == 3'h0 |-> pick[0]) else $error("default table not chosen");
  a_na_no_src: assert property (@(posedge clk) disable iff (!rst_n)
    enable_reg && any && !src_ok_reg[idx] |=> sel_na) else $error("na missing");
  a_hold_done: assert property (@(posedge clk) disable iff (!rst_n)
    (done_reg[0] || gen_prof[0].last) && ctrl_in[0] ##1 ctrl_in[0] && $stable(py_reg) &&
    $stable(pr_reg) |-> $stable(prof_out[0])) else $error("final output not held");
  a_op_guard: assert property (@(posedge clk) disable iff (!rst_n)
    !a1_used_reg[0] |-> op_reg[0] == 3'h0) else $error("operator without args");
  a_na_unused: assert property (@(posedge clk) disable iff (!rst_n)
    !a2_used_reg[0] |-> res[0] == cts_pkg::CTS_RES_NA) else $error("unused not na");
  a_err_result: assert property (@(posedge clk) disable iff (!rst_n)
    a1_used_reg[0] && a2_used_reg[0] && arg_err[1] |-> res[0] == cts_pkg::CTS_RES_ERR)
    else $error("error argument not reported");
  c_profile_done: cover property (@(posedge clk) disable iff (!rst_n) $rose(done_reg[0]));
  c_cond_error: cover property (@(posedge clk) disable iff (!rst_n) res[0] == cts_pkg::CTS_RES_ERR);
  c_pick_second: cover property (@(posedge clk) disable iff (!rst_n) sel_idx == 2'h1);
  c_not_avail: cover property (@(posedge clk) disable iff (!rst_n) sel_na);
endmodule
`default_nettype wire

/* File: shared/cts_pkg.sv */
package cts_pkg;
  typedef enum logic [1:0] {CTS_RES_FALSE, CTS_RES_TRUE, CTS_RES_ERR, CTS_RES_NA} cts_res_t;
  typedef enum logic [2:0] {CTS_OP_EQ, CTS_OP_NE, CTS_OP_GT, CTS_OP_GE, CTS_OP_LT,
    CTS_OP_LE} cts_op_t;
  typedef enum logic [2:0] {CTS_CMB_DEFAULT, CTS_CMB_AND3, CTS_CMB_OR3, CTS_CMB_ANDOR,
    CTS_CMB_ORAND} cts_cmb_t;
  typedef enum logic [1:0] {CTS_PT_RAMP, CTS_PT_JUMP, CTS_PT_IGNORE} cts_pt_t;
endpackage

/* File: shared/cts_regs.svh */
`ifndef CTS_REGS_SVH
`define CTS_REGS_SVH
`define CTS_ADDR_W 8
`define CTS_DATA_W 32
`define CTS_NPTS 11
`define CTS_MS_NS 1000000
`define CTS_CLK_NS 4
`define CTS_MS_CYC (`CTS_MS_NS / `CTS_CLK_NS)
`define CTS_DAY_MS 32'h0526_5c00
`define CTS_A_CTRL 8'h00
`define CTS_A_STAT 8'h04
`define CTS_A_OUT 8'h08
`define CTS_A_MODE 8'h0c
`define CTS_A_TBLSRC 8'h10
`define CTS_A_COND 8'h20
`define CTS_A_PX 8'h40
`define CTS_A_PY 8'h80
`define CTS_A_PR 8'hc0
`define CTS_NO_READ 32'h0000_0000
`define CTS_MODE_RST 12'h011
`define CTS_PX_MIN 27'h000_0001
`endif

/* File: testbench/condition_table_selector_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cts_regs.svh"
module condition_table_selector_test;
  logic clk;
  logic nrst;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [8:0][15:0] arg_val;
  logic [8:0] arg_err;
  logic [2:0] ctrl_in;
  logic [2:0][15:0] data_tbl_out;
  logic [15:0] sel_out;
  logic sel_na;
  logic [1:0] sel_idx;
  logic sel_valid;
  logic [15:0] held_val;
  logic [31:0] d;
  int bad_count;
  int checks;

  cts_selector u_cts_selector (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .arg_val(arg_val), .arg_err(arg_err), .ctrl_in(ctrl_in),
    .data_tbl_out(data_tbl_out), .sel_out(sel_out), .sel_na(sel_na), .sel_idx(sel_idx),
    .sel_valid(sel_valid));
  cts_consumer u_cts_consumer (.clk(clk), .nrst(nrst), .sel_out(sel_out), .sel_na(sel_na),
    .sel_valid(sel_valid), .held_val(held_val));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Register write lands one cycle late, selector adds one more
  task automatic expect_sel(input logic [1:0] idx);
    repeat (3) @(posedge clk);
    #1;
    chk("sel_valid", 32'h1, {31'h0, sel_valid});
    chk("sel_idx", {30'h0, idx}, {30'h0, sel_idx});
    chk("sel_out", {16'h0, 16'h1111 * {14'h0, idx} + 16'h1111}, {16'h0, sel_out});
  endtask

  function automatic logic pick(input logic [2:0] m, input logic [2:0] c);
    case (m)
      3'h1: pick = &c;
      3'h2: pick = |c;
      3'h3: pick = (c[0] & c[1]) | c[2];
      3'h4: pick = (c[0] | c[1]) & c[2];
      default: pick = 1'b1;
    endcase
  endfunction

  task automatic t_reset();
    rd_reg(`CTS_A_CTRL);
    chk("ctrl", 32'h0000_0000, d);
    rd_reg(`CTS_A_MODE);
    chk("mode", 32'h0000_0011, d);
    rd_reg(`CTS_A_COND);
    chk("cond", 32'h0000_0000, d);
    rd_reg(8'hfc);
    chk("unmapped", 32'h0000_0000, d);
    chk("sel_valid", 32'h0, {31'h0, sel_valid});
    wr_reg(`CTS_A_CTRL, 32'h0000_0071);
    expect_sel(2'h0);
    chk("held_val", 32'h0000_1111, {16'h0, held_val});
    rd_reg(`CTS_A_OUT);
    chk("out_reg", 32'h0000_1111, d);
  endtask

  task automatic t_ops();
    logic [1:0][5:0] truth;
    truth = {6'b101001, 6'b001110};
    for (int b = 0; b < 2; b++) begin
      @(posedge clk);
      arg_val[0] <= (b == 0) ? 16'h0005 : 16'h0003;
      arg_val[1] <= 16'h0003;
      for (int op = 0; op < 6; op++) begin
        wr_reg(`CTS_A_COND, {25'h0, op[2:0], 4'h3});
        expect_sel(truth[b][op] ? 2'h0 : 2'h1);
      end
    end
    wr_reg(`CTS_A_COND, 32'h0000_0021);
    rd_reg(`CTS_A_COND);
    chk("cond_op_lock", 32'h0000_0001, d);
  endtask

  task automatic t_modes();
    @(posedge clk);
    arg_val <= '0;
    for (int m = 0; m < 5; m++) begin
      for (int p = 0; p < 8; p++) begin
        for (int k = 0; k < 3; k++) begin
          wr_reg(`CTS_A_COND + 8'(4 * k), p[k] ? 32'h0000_0003 : 32'h0000_0013);
        end
        wr_reg(`CTS_A_MODE, 32'(m));
        expect_sel(pick(m[2:0], p[2:0]) ? 2'h0 : 2'h1);
      end
    end
  endtask

  task automatic t_err();
    wr_reg(`CTS_A_COND + 8'h04, 32'h0000_0000);
    wr_reg(`CTS_A_COND + 8'h08, 32'h0000_0000);
    wr_reg(`CTS_A_COND, 32'h0000_0033);
    wr_reg(`CTS_A_MODE, 32'h0000_0011);
    expect_sel(2'h0);
    @(posedge clk);
    arg_err[1] <= 1'b1;
    expect_sel(2'h1);
    wr_reg(`CTS_A_MODE, 32'h0000_0012);
    expect_sel(2'h1);
    @(posedge clk);
    arg_err[1] <= 1'b0;
    expect_sel(2'h0);
  endtask

  task automatic t_time();
    wr_reg(`CTS_A_PY, 32'h0000_0000);
    wr_reg(`CTS_A_CTRL, 32'h0000_0073);
    repeat (3) @(posedge clk);
    #1;
    chk("time_off", 32'h0, {16'h0, sel_out});
    @(posedge clk);
    ctrl_in[0] <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("time_start", 32'h0, {16'h0, sel_out});
    wr_reg(`CTS_A_PY + 8'h04, 32'h0000_0abc);
    wr_reg(`CTS_A_PR + 8'h04, 32'h0000_0001);
    repeat (3) @(posedge clk);
    #1;
    chk("time_jump", 32'h0000_0abc, {16'h0, sel_out});
    wr_reg(`CTS_A_PR + 8'h04, 32'h0000_0002);
    repeat (3) @(posedge clk);
    #1;
    chk("time_ignore", 32'h0, {16'h0, sel_out});
    wr_reg(`CTS_A_PR + 8'h04, 32'h0000_0001);
    @(posedge clk);
    ctrl_in[0] <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("time_off_again", 32'h0, {16'h0, sel_out});
  endtask

  task automatic t_na();
    wr_reg(`CTS_A_CTRL, 32'h0000_0061);
    repeat (3) @(posedge clk);
    #1;
    chk("sel_na", 32'h1, {31'h0, sel_na});
    rd_reg(`CTS_A_STAT);
    chk("status", 32'h0000_0030, d);
    wr_reg(`CTS_A_CTRL, 32'h0000_0070);
    repeat (3) @(posedge clk);
    #1;
    chk("disabled", 32'h0, {31'h0, sel_valid});
  endtask

  task automatic final_report();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    arg_val = '0;
    arg_err = 9'h000;
    ctrl_in = 3'h0;
    data_tbl_out = {16'h3333, 16'h2222, 16'h1111};
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    // Internal reset copy needs two edges before access
    repeat (4) @(posedge clk);
    t_reset();
    t_ops();
    t_modes();
    t_err();
    t_time();
    t_na();
    final_report();
  end

  // Whole run needs about six hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    final_report();
  end
endmodule
`default_nettype wire

/* File: testbench/cts_consumer.sv */
`timescale 1ns/100ps
`default_nettype none
module cts_consumer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] sel_out,
  input wire logic sel_na,
  input wire logic sel_valid,
  output logic [15:0] held_val
);
  // Keeps the last usable value; a not-available output is never consumed
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      held_val <= 16'h0000;
    end else if (sel_valid && !sel_na) begin
      held_val <= sel_out;
    end
  end
endmodule
`default_nettype wire
